// >>> design/pcsp_core.sv
// module: program counter sequencer with paging latch and wishbone registers
`timescale 1ns/10ps
`default_nettype none
module pcsp_core (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire pcsp_pkg::pcsp_cmd_t  cmd_i,
  output logic [pcsp_pkg::PC_W-1:0] pc_o
);

  // ----------------------------------------
  // decode helper
  // ----------------------------------------
  function automatic logic reg_hit(
    input logic [7:0] adr,
    input logic [5:0] off
  );
    reg_hit = (adr[7:2] == off);
  endfunction : reg_hit

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic                             ack_ff;
  logic                             nxt_ack;
  logic [31:0]                      rdat_ff;
  logic [31:0]                      nxt_rdat;
  logic [pcsp_pkg::PC_W-1:0]        pc_ff;
  logic [pcsp_pkg::PC_W-1:0]        nxt_pc;
  logic [pcsp_pkg::LATCH_W-1:0]     latch_ff;
  logic [pcsp_pkg::LATCH_W-1:0]     nxt_latch;
  logic                             req;
  logic                             wr;
  logic                             wr_low;
  logic                             wr_add;
  logic                             wr_latch;
  logic                             cmd_take;
  logic                             push;
  logic                             pop;
  logic [pcsp_pkg::PC_W-1:0]        push_val;
  logic [pcsp_pkg::PC_W-1:0]        top;
  logic [pcsp_pkg::LOW_W-1:0]       add_sum;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign req      = wb_cyc_i && wb_stb_i;
  assign wr       = req && wb_we_i && ack_ff && wb_sel_i[0];
  assign wr_low   = wr && reg_hit(wb_adr_i, pcsp_pkg::OFF_LOW_BYTE);
  assign wr_add   = wr && reg_hit(wb_adr_i, pcsp_pkg::OFF_ADD_LOW);
  assign wr_latch = wr && reg_hit(wb_adr_i, pcsp_pkg::OFF_LATCH);

  always_comb
  begin
    nxt_ack  = req && !ack_ff;
    nxt_rdat = rdat_ff;
    if (req && !ack_ff)
    begin
      nxt_rdat = 32'h0000_0000;
      if (reg_hit(wb_adr_i, pcsp_pkg::OFF_LOW_BYTE) ||
          reg_hit(wb_adr_i, pcsp_pkg::OFF_ADD_LOW))
      begin
        nxt_rdat[pcsp_pkg::LOW_W-1:0] = pc_ff[pcsp_pkg::LOW_W-1:0];
      end
      else if (reg_hit(wb_adr_i, pcsp_pkg::OFF_LATCH))
      begin
        nxt_rdat[pcsp_pkg::LATCH_W-1:0] = latch_ff;
      end
      else if (reg_hit(wb_adr_i, pcsp_pkg::OFF_PC_STAT))
      begin
        nxt_rdat = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------
  // high latch
  // ----------------------------------------
  always_comb
  begin
    nxt_latch = latch_ff;
    if (wr_latch)
    begin
      nxt_latch = wb_dat_i[pcsp_pkg::LATCH_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_ff <= pcsp_pkg::LATCH_RST;
    end
    else
    begin
      latch_ff <= nxt_latch;
    end
  end

  // ----------------------------------------
  // counter sequencing
  // ----------------------------------------
  assign cmd_take = cmd_i.valid && !wr_low && !wr_add;
  assign add_sum  = pc_ff[pcsp_pkg::LOW_W-1:0] + wb_dat_i[pcsp_pkg::LOW_W-1:0];

  always_comb
  begin
    nxt_pc   = pc_ff;
    push     = 1'b0;
    pop      = 1'b0;
    push_val = pc_ff;
    if (wr_low)
    begin
      nxt_pc = {latch_ff, wb_dat_i[pcsp_pkg::LOW_W-1:0]};
    end
    else if (wr_add)
    begin
      nxt_pc = {latch_ff, add_sum};
    end
    else if (cmd_i.valid)
    begin
      unique case (cmd_i.op)
        pcsp_pkg::PCSP_OP_HOLD:
        begin
          nxt_pc = pc_ff;
        end
        pcsp_pkg::PCSP_OP_STEP:
        begin
          nxt_pc = pc_ff + pcsp_pkg::PC_ONE;
        end
        pcsp_pkg::PCSP_OP_JUMP:
        begin
          nxt_pc = {latch_ff[pcsp_pkg::PAGE_HI:pcsp_pkg::PAGE_LO], cmd_i.target};
        end
        pcsp_pkg::PCSP_OP_CALL:
        begin
          push     = 1'b1;
          push_val = pc_ff + pcsp_pkg::PC_ONE;
          nxt_pc   = {latch_ff[pcsp_pkg::PAGE_HI:pcsp_pkg::PAGE_LO], cmd_i.target};
        end
        pcsp_pkg::PCSP_OP_RET:
        begin
          pop    = 1'b1;
          nxt_pc = top;
        end
        pcsp_pkg::PCSP_OP_VECT:
        begin
          push     = 1'b1;
          push_val = pc_ff;
          nxt_pc   = pcsp_pkg::VECTOR_PC;
        end
        default:
        begin
          nxt_pc = pc_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_ff <= pcsp_pkg::PC_RST;
    end
    else
    begin
      pc_ff <= nxt_pc;
    end
  end

  assign pc_o = pc_ff;

  // ----------------------------------------
  // return stack
  // ----------------------------------------
  // no overflow status
  pcsp_stack u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (push_val),
    .top_o       (top)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> pc_ff == 13'h0000)
    else $error("counter not cleared by reset");

  a_low_write: assert property (wr_low |=>
    pc_ff == {$past(latch_ff), $past(wb_dat_i[7:0])})
    else $error("low write did not load counter from latch");

  a_add_no_carry: assert property (wr_add |=>
    pc_ff[12:8] == $past(latch_ff) &&
    pc_ff[7:0] == $past(pc_ff[7:0]) + $past(wb_dat_i[7:0]))
    else $error("computed jump carried into upper bits");

  a_jump_page: assert property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_JUMP |=>
    pc_ff == {$past(latch_ff[4:3]), $past(cmd_i.target)})
    else $error("jump target wrong");

  a_call_return: assert property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_CALL
    ##1 cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_RET |=>
    pc_ff == $past(pc_ff, 2) + 13'h0001)
    else $error("return did not restore call address");

  a_ret_full: assert property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_RET |=>
    pc_ff == $past(top))
    else $error("return did not restore all counter bits");

  a_latch_keep: assert property ((push || pop) && !wr_latch |=>
    $stable(latch_ff))
    else $error("latch changed by stack action");

  a_vector_go: assert property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_VECT |=>
    pc_ff == pcsp_pkg::VECTOR_PC && top == $past(pc_ff))
    else $error("vector did not push and branch");

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  a_unmapped_zero: assert property (req && !ack_ff && wb_adr_i[7:4] != 4'h0 |=>
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // register and sequencer checks
  // ----------------------------------------
  a_upper_hidden: assert property (
    req && !ack_ff && reg_hit(wb_adr_i, pcsp_pkg::OFF_PC_STAT) |=> wb_dat_o == 32'h0000_0000)
    else $error("upper counter bits readable");

  a_ack_answer: assert property (
    req && !ack_ff |=> wb_ack_o)
    else $error("request not answered next cycle");

  a_ack_idle: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without request");

  a_rdat_hold: assert property (
    !(req && !ack_ff) |=> $stable(wb_dat_o))
    else $error("read data changed outside a request");

  a_read_low: assert property (
    req && !ack_ff && reg_hit(wb_adr_i, pcsp_pkg::OFF_LOW_BYTE) |=>
    wb_dat_o == {24'h00_0000, $past(pc_ff[7:0])})
    else $error("low byte read wrong");

  a_read_add: assert property (
    req && !ack_ff && reg_hit(wb_adr_i, pcsp_pkg::OFF_ADD_LOW) |=>
    wb_dat_o == {24'h00_0000, $past(pc_ff[7:0])})
    else $error("add register read wrong");

  a_read_latch: assert property (
    req && !ack_ff && reg_hit(wb_adr_i, pcsp_pkg::OFF_LATCH) |=>
    wb_dat_o == {27'h0, $past(latch_ff)})
    else $error("latch read wrong");

  a_latch_load: assert property (
    wr_latch |=> latch_ff == $past(wb_dat_i[4:0]))
    else $error("latch write not loaded");

  a_latch_only_write: assert property (
    !wr_latch |=> $stable(latch_ff))
    else $error("latch changed without a write");

  a_sel_ignored: assert property (
    req && wb_we_i && ack_ff && !wb_sel_i[0] && !cmd_i.valid |=>
    $stable(pc_ff) && $stable(latch_ff))
    else $error("write without lane zero took effect");

  a_step_inc: assert property (
    cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_STEP |=>
    pc_ff == $past(pc_ff) + 13'h0001)
    else $error("step did not advance counter");

  a_hold_keep: assert property (
    cmd_take && (cmd_i.op == pcsp_pkg::PCSP_OP_HOLD || cmd_i.op > pcsp_pkg::PCSP_OP_VECT)
    |=> $stable(pc_ff))
    else $error("hold changed counter");

  a_call_push: assert property (
    cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_CALL |=>
    top == $past(pc_ff) + 13'h0001)
    else $error("call did not push return address");

  a_call_page: assert property (
    cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_CALL |=>
    pc_ff == {$past(latch_ff[4:3]), $past(cmd_i.target)})
    else $error("call target wrong");

  a_jump_stack: assert property (
    cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_JUMP |=> $stable(top))
    else $error("jump touched the stack");

  c_call: cover property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_CALL);
  c_ret: cover property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_RET);
  c_vect: cover property (cmd_take && cmd_i.op == pcsp_pkg::PCSP_OP_VECT);
  c_add: cover property (wr_add);

endmodule : pcsp_core
`default_nettype wire

// >>> design/pcsp_pkg.sv
// package: program counter, return stack and paging constants and types
//
// Function
// - the counter is 13 bits wide and its low byte is read and written by software.
// - counter bits 12 to 8 have no direct access; a software write of the low byte loads them from the high latch.
// - every reset clears the whole counter to zero.
// - a software write of the low byte loads the upper five bits from latch bits 4 to 0.
// - call and jump take 11 low bits from the instruction and 2 upper bits from latch bits 4 and 3.
// - an add into the low byte is a computed jump whose carry is dropped, landing in the 256 block chosen by latch bits 4 to 0.
// - a hardware return stack of eight 13-bit entries lies outside program and data space.
// - the stack pointer is hidden from software.
// - a call pushes the counter plus one and an interrupt vector pushes the counter onto the stack.
// - plain return, return with literal and return from interrupt pop the stack into the counter.
// - pushes and pops leave the high latch unchanged.
// - the stack is circular, the ninth push overwriting the first.
// - no overflow or underflow status exists.
// - program space is 8K words in 2K pages chosen by the two upper counter bits.
// - a return restores all 13 counter bits from the stack, ignoring the latch page bits.
package pcsp_pkg;

  localparam int PC_W    = 13;
  localparam int LOW_W   = 8;
  localparam int LATCH_W = 5;
  localparam int TGT_W   = 11;
  localparam int DEPTH   = 8;
  localparam int PTR_W   = 3;
  localparam int PAGE_LO = 3;
  localparam int PAGE_HI = 4;

  localparam logic [5:0] OFF_LOW_BYTE = 6'h00;
  localparam logic [5:0] OFF_LATCH    = 6'h01;
  localparam logic [5:0] OFF_ADD_LOW  = 6'h02;
  localparam logic [5:0] OFF_PC_STAT  = 6'h03;

  localparam logic [PC_W-1:0]    PC_RST     = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST  = 5'h00;
  localparam logic [PTR_W-1:0]   PTR_RST    = 3'h0;
  localparam logic [PC_W-1:0]    VECTOR_PC  = 13'h0004;
  localparam logic [PC_W-1:0]    PC_ONE     = 13'h0001;

  typedef enum logic [2:0] {
    PCSP_OP_HOLD = 3'b000,
    PCSP_OP_STEP = 3'b001,
    PCSP_OP_JUMP = 3'b010,
    PCSP_OP_CALL = 3'b011,
    PCSP_OP_RET  = 3'b100,
    PCSP_OP_VECT = 3'b101
  } pcsp_op_t;

  typedef struct packed {
    logic              valid;
    pcsp_op_t          op;
    logic [TGT_W-1:0]  target;
  } pcsp_cmd_t;

endpackage : pcsp_pkg

// >>> design/pcsp_stack.sv
// module: eight-entry circular return stack with hidden pointer
`timescale 1ns/10ps
`default_nettype none
module pcsp_stack (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       push_i,
  input  wire logic                       pop_i,
  input  wire logic [pcsp_pkg::PC_W-1:0]  push_data_i,
  output logic      [pcsp_pkg::PC_W-1:0]  top_o
);

  logic [pcsp_pkg::PTR_W-1:0] ptr_ff;
  logic [pcsp_pkg::PTR_W-1:0] nxt_ptr;
  logic [pcsp_pkg::PTR_W-1:0] top_idx;
  logic [pcsp_pkg::PC_W-1:0]  mem_ff [pcsp_pkg::DEPTH];

  // ----------------------------------------
  // pointer
  // ----------------------------------------
  assign top_idx = ptr_ff - 3'h1;
  assign top_o   = mem_ff[top_idx];

  always_comb
  begin
    nxt_ptr = ptr_ff;
    if (push_i)
    begin
      nxt_ptr = ptr_ff + 3'h1;
    end
    else if (pop_i)
    begin
      nxt_ptr = top_idx;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ptr_ff <= pcsp_pkg::PTR_RST;
    end
    else
    begin
      ptr_ff <= nxt_ptr;
    end
  end

  // ----------------------------------------
  // entries
  // ----------------------------------------
  for (genvar gi = 0; gi < pcsp_pkg::DEPTH; gi++)
  begin : g_entry
    logic [pcsp_pkg::PC_W-1:0] nxt_ent;
    always_comb
    begin
      nxt_ent = mem_ff[gi];
      if (push_i && (ptr_ff == 3'(gi)))
      begin
        nxt_ent = push_data_i;
      end
    end
    always_ff @(posedge clk_i)
    begin
      mem_ff[gi] <= nxt_ent;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_push_stored: assert property (push_i |=> top_o == $past(push_data_i))
    else $error("pushed value not on top");
  a_ptr_wrap: assert property (pop_i && !push_i |=> ptr_ff == $past(top_idx))
    else $error("pop pointer not decremented modulo eight");
  a_ptr_push: assert property (push_i |=> ptr_ff == $past(ptr_ff) + 3'h1)
    else $error("push pointer not incremented modulo eight");
  c_wrap_push: cover property (push_i && ptr_ff == 3'h7);

endmodule : pcsp_stack
`default_nettype wire

// >>> bench/pcsp_decoder_model.sv
// file: behavioural decoder model issuing sequencer commands
`timescale 1ns/10ps
`default_nettype none
module pcsp_decoder_model (
  input  wire logic               clk_i,
  output var pcsp_pkg::pcsp_cmd_t cmd_o
);
  initial
  begin
    cmd_o = '{valid: 1'b0, op: pcsp_pkg::PCSP_OP_HOLD, target: 11'h7FF};
  end
  // one command valid for one edge, optional idle gap, scrambled when idle
  task automatic issue(input pcsp_pkg::pcsp_op_t op, input logic [10:0] tgt, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: op, target: tgt};
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b0, op: pcsp_pkg::PCSP_OP_HOLD, target: ~tgt};
  endtask : issue
  // two commands on consecutive edges, then idle
  task automatic issue2(input pcsp_pkg::pcsp_op_t op_a, input logic [10:0] tgt_a,
                        input pcsp_pkg::pcsp_op_t op_b, input logic [10:0] tgt_b);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: op_a, target: tgt_a};
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: op_b, target: tgt_b};
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b0, op: pcsp_pkg::PCSP_OP_HOLD, target: ~tgt_b};
  endtask : issue2
endmodule : pcsp_decoder_model
`default_nettype wire

// >>> bench/pcsp_core_tb.sv
// file: self-checking bench for the program counter sequencer
`timescale 1ns/10ps
`default_nettype none
module pcsp_core_tb;
  logic                clk_i;
  logic                rst_i;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_we_i;
  logic [7:0]          wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [31:0]         wb_dat_i;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  pcsp_pkg::pcsp_cmd_t cmd;
  logic [12:0]         pc_o;
  logic [12:0]         exp_pc;
  logic [4:0]          exp_latch;
  logic [12:0]         stk [8];
  logic [2:0]          sp;
  logic [31:0]         rd;
  logic [31:0]         v;
  pcsp_pkg::pcsp_op_t  op;
  integer              seed = 52969;
  int                  bad_count = 0;
  int                  n_compared = 0;

  pcsp_core pcsp_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_i(cmd),
    .pc_o(pc_o));
  pcsp_decoder_model pcsp_decoder_model_inst (.clk_i(clk_i), .cmd_o(cmd));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // checks and bus cycles
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    chk("ack wait", 32'h0000_0002, n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    #1;
  endtask : wb

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, 4'hF);
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic wr_latch(input logic [31:0] d);
    wb(1'b1, 8'h04, d, 4'hF);
    exp_latch = d[4:0];
  endtask : wr_latch

  task automatic wr_low(input logic [7:0] adr, input logic [31:0] d);
    wb(1'b1, adr, d, 4'hF);
    exp_pc = {exp_latch, (adr == 8'h08) ? exp_pc[7:0] + d[7:0] : d[7:0]};
    chk("pc_o", {19'h0, exp_pc}, {19'h0, pc_o});
  endtask : wr_low

  // expected sequencer and stack behaviour
  task automatic do_cmd(input pcsp_pkg::pcsp_op_t o, input logic [10:0] t, input int gap);
    pcsp_decoder_model_inst.issue(o, t, gap);
    case (o)
      pcsp_pkg::PCSP_OP_STEP: exp_pc = exp_pc + 13'h0001;
      pcsp_pkg::PCSP_OP_JUMP: exp_pc = {exp_latch[4:3], t};
      pcsp_pkg::PCSP_OP_CALL:
      begin
        stk[sp] = exp_pc + 13'h0001;
        sp = sp + 3'h1;
        exp_pc = {exp_latch[4:3], t};
      end
      pcsp_pkg::PCSP_OP_RET:
      begin
        sp = sp - 3'h1;
        exp_pc = stk[sp];
      end
      pcsp_pkg::PCSP_OP_VECT:
      begin
        stk[sp] = exp_pc;
        sp = sp + 3'h1;
        exp_pc = pcsp_pkg::VECTOR_PC;
      end
      default: exp_pc = exp_pc;
    endcase
    #1;
    chk("pc_o", {19'h0, exp_pc}, {19'h0, pc_o});
  endtask : do_cmd

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    #400000;
    bad_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    exp_pc = 13'h0000;
    exp_latch = 5'h00;
    sp = 3'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("pc hidden", 8'h0C, 32'h0);
    chk("pc_o", 32'h0, {19'h0, pc_o});
    rd_chk("latch", 8'h04, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr_latch($random(seed));
      rd_chk("latch", 8'h04, {27'h0, exp_latch});
      wr_low(8'h00, $random(seed));
      rd_chk("low byte", 8'h00, {24'h0, exp_pc[7:0]});
      rd_chk("pc hidden", 8'h0C, 32'h0);
    end
    wb(1'b1, 8'h0C, 32'h0000_1FFF, 4'hF);
    wb(1'b1, 8'h00, 32'h0000_00A5, 4'hE);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
    rd_chk("pc hidden", 8'h0C, 32'h0);
    chk("pc_o", {19'h0, exp_pc}, {19'h0, pc_o});
    rd_chk("unmapped", 8'h10, 32'h0);
    wr_low(8'h00, 32'h0000_00F0);
    wr_low(8'h08, 32'h0000_0020);
    rd_chk("add read", 8'h08, {24'h0, exp_pc[7:0]});
    $display("test registers done");
    wr_latch(32'h0000_0018);
    do_cmd(pcsp_pkg::PCSP_OP_JUMP, 11'h7FF, 0);
    do_cmd(pcsp_pkg::PCSP_OP_STEP, 11'h000, 1);
    for (int i = 0; i < 40; i++)
    begin
      v = $random(seed);
      if (i % 4 == 0)
        wr_latch(v);
      op = (i < 12) ? pcsp_pkg::PCSP_OP_CALL : (i < 22) ? pcsp_pkg::PCSP_OP_RET :
           pcsp_pkg::pcsp_op_t'(v[10:8]);
      do_cmd(op, v[21:11], int'(v[23:22]));
    end
    rd_chk("latch", 8'h04, {27'h0, exp_latch});
    do_cmd(pcsp_pkg::PCSP_OP_VECT, 11'h155, 0);
    do_cmd(pcsp_pkg::PCSP_OP_RET, 11'h2AA, 0);
    do_cmd(pcsp_pkg::PCSP_OP_HOLD, 11'h0F0, 2);
    rd_chk("latch", 8'h04, {27'h0, exp_latch});
    $display("test stack done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    exp_pc = 13'h0000;
    exp_latch = 5'h00;
    sp = 3'h0;
    chk("pc_o", 32'h0, {19'h0, pc_o});
    do_cmd(pcsp_pkg::PCSP_OP_CALL, 11'h3C3, 0);
    do_cmd(pcsp_pkg::PCSP_OP_RET, 11'h000, 0);
    stk[sp] = exp_pc + 13'h0001;
    pcsp_decoder_model_inst.issue2(pcsp_pkg::PCSP_OP_CALL, 11'h0A5,
                                   pcsp_pkg::PCSP_OP_RET, 11'h000);
    exp_pc = stk[sp];
    #1;
    chk("pc_o", {19'h0, exp_pc}, {19'h0, pc_o});
    $display("test second reset done");
    complete_run();
  end
endmodule : pcsp_core_tb
`default_nettype wire
